//--- logic/tsa_status_alarm.v
// Purpose: Temperature status output, heat-up supervision, restart delay,
//          measurement pause limit, message log and alarm indicator
// Assumes: Start, reset and constant power pins are asynchronous
// Notes:   Temperatures in kelvin, unsigned 12 bit; ticks are 1 ms
`timescale 1ns/100ps
`include "tsa_defs.vh"

// Operation
// - Status output on band or 95 percent
// - Constant power request forces status off
// - Four selectable output modes
// - Off mode keeps status low
// - Threshold mode asserts above 95 percent
// - Threshold clears on start low, alarm
// - Following mode asserts in band, start high, no alarm
// - Latched mode drops on leaving band
// - Latched mode stays low after re-entry
// - Latched clears on start edge, alarm or leaving band
// - Heat-up supervision has enable bit
// - Heat-up timeout raises error 304, alarm
// - Restart delay blocks pulses and diagnosis
// - Restart delay default 0.2 s, adjustable
// - Overshoot reduces power, then pauses pulses
// - Pause at most 10 periods, shortenable
// - Log last 400 messages with time
// - Unset clock logs invalid time stamp
// - Blink 4 Hz for zero calibration errors
// - Blink 1 Hz for errors 111 to 114
// - Steady light for start-blocking malfunctions
// - Start turns blinking into steady light
// - Band limits default minus, plus 10 K
// - Error cleared on falling reset edge
module tsa_status_alarm (
	input  wire        clk,
	input  wire        reset,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        startPin,
	input  wire        resetPin,
	input  wire        constantPowerRequestPin,
	input  wire [11:0] actualTemp,
	input  wire [11:0] setpointTemp,
	input  wire        mainsPeriod,
	input  wire        errEvent,
	input  wire [9:0]  errCode,
	output reg         tempStatus,
	output reg         alarmOut,
	output reg         alarmLed,
	output reg         measureEnable,
	output reg         powerReduce,
	output reg  [9:0]  activeError
);

	// ==================================================
	// Sized copies of the timing and log constants
	localparam integer TICK_LAST_I  = `TSA_TICK_CYC - 1;
	localparam integer BLINK_LAST_I = `TSA_BLINK4_MS - 1;
	localparam integer LOG_LAST_I   = `TSA_LOG_DEPTH - 1;
	localparam integer LOG_DEPTH_I  = `TSA_LOG_DEPTH;

	// ==================================================
	// Decoding helpers
	function [1:0] ledClass;
		input [9:0] code;
		begin
			if ((code >= 10'd104 && code <= 10'd106) || code == 10'd211 ||
				code == 10'd302 || code == 10'd303)
				ledClass = 2'h1;
			else if (code >= 10'd111 && code <= 10'd114)
				ledClass = 2'h2;
			else if (code != 10'd0)
				ledClass = 2'h3;
			else
				ledClass = 2'h0;
		end
	endfunction

	// ==================================================
	// Pin synchronisers
	reg  [1:0]  startSync_q;
	reg  [1:0]  rstSync_q;
	reg  [1:0]  cprSync_q;
	reg         startPrev_q;
	reg         rstPrev_q;
	wire        startOn  = startSync_q[1];
	wire        rstOn    = rstSync_q[1];
	wire        cprOn    = cprSync_q[1];
	wire        startRise = startOn & ~startPrev_q;
	wire        rstFall  = ~rstOn & rstPrev_q;

	always @(posedge clk) begin
		if (reset) begin
			startSync_q <= 2'h0;
			rstSync_q   <= 2'h0;
			cprSync_q   <= 2'h0;
			startPrev_q <= 1'b0;
			rstPrev_q   <= 1'b0;
		end else begin
			startSync_q <= {startSync_q[0], startPin};
			rstSync_q   <= {rstSync_q[0], resetPin};
			cprSync_q   <= {cprSync_q[0], constantPowerRequestPin};
			startPrev_q <= startOn;
			rstPrev_q   <= rstOn;
		end
	end

	// ==================================================
	// Registers
	reg  [3:0]  ctrl_q;
	reg  [7:0]  bandLo_q;
	reg  [7:0]  bandHi_q;
	reg  [15:0] heatLim_q;
	reg  [15:0] restartMs_q;
	reg  [3:0]  pauseMax_q;
	reg  [8:0]  logIdx_q;
	reg  [31:0] clock_q;
	wire [1:0]  mode   = ctrl_q[`TSA_CTRL_MODE_HI:`TSA_CTRL_MODE_LO];
	wire        huEn   = ctrl_q[`TSA_CTRL_HUEN];
	wire        clkSet = ctrl_q[`TSA_CTRL_CLKSET];
	wire        wrEn   = psel & penable & pwrite;

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always @(posedge clk) begin
		if (reset) begin
			ctrl_q      <= `TSA_RST_CTRL;
			bandLo_q    <= `TSA_RST_BANDLO;
			bandHi_q    <= `TSA_RST_BANDHI;
			heatLim_q   <= `TSA_RST_HEATLIM;
			restartMs_q <= `TSA_RESTART_MS;
			pauseMax_q  <= `TSA_RST_PAUSE;
			logIdx_q    <= 9'h0;
		end else if (wrEn) begin
			case (paddr)
				`TSA_OFF_CTRL:    ctrl_q <= pwdata[3:0];
				`TSA_OFF_BAND: begin
					bandLo_q <= pwdata[7:0];
					bandHi_q <= pwdata[15:8];
				end
				`TSA_OFF_HEATLIM: heatLim_q <= pwdata[15:0];
				`TSA_OFF_RESTART: restartMs_q <= pwdata[15:0];
				`TSA_OFF_PAUSE: pauseMax_q <= (pwdata[3:0] > `TSA_RST_PAUSE) ?
					`TSA_RST_PAUSE : pwdata[3:0];
				`TSA_OFF_LOGIDX:  logIdx_q <= pwdata[8:0];
				default: ;
			endcase
		end
	end

	// ==================================================
	// Millisecond tick and time base
	reg  [16:0] tickCnt_q;
	wire        tick = (tickCnt_q == 17'd0);
	always @(posedge clk) begin
		if (reset || tick)
			tickCnt_q <= TICK_LAST_I[16:0];
		else
			tickCnt_q <= tickCnt_q - 17'd1;
	end

	always @(posedge clk) begin
		if (reset)
			clock_q <= 32'h0;
		else if (wrEn && paddr == `TSA_OFF_CLOCK)
			clock_q <= pwdata;
		else if (tick)
			clock_q <= clock_q + 32'h1;
	end

	// ==================================================
	// Temperature comparisons
	// Product widened so a hot setpoint cannot wrap
	wire [16:0] actScaled = {5'h0, actualTemp} * 17'd`TSA_RATIO_DEN;
	wire [16:0] setScaled = {5'h0, setpointTemp} * 17'd`TSA_RATIO_NUM;
	wire        reached   = actScaled > setScaled;
	wire [12:0] lowLim    = {1'b0, setpointTemp} - {5'h0, bandLo_q};
	wire [12:0] highLim   = {1'b0, setpointTemp} + {5'h0, bandHi_q};
	wire        inBand    = ({1'b0, actualTemp} >= lowLim) &&
	                        ({1'b0, actualTemp} <= highLim) && !lowLim[12];
	wire        over      = actualTemp > setpointTemp;

	// ==================================================
	// Error state and alarm
	reg  [15:0] heatCnt_q;
	reg         heatRun_q;
	reg  [15:0] restartCnt_q;
	wire        restartBusy = (restartCnt_q != 16'h0);
	wire        heatTimeout = heatRun_q && huEn && (heatCnt_q >= heatLim_q) && tick;
	wire        newErr      = (errEvent && !restartBusy) || heatTimeout;
	wire [9:0]  newCode     = heatTimeout ? `TSA_ERR_HEATUP : errCode;
	wire [1:0]  cls         = ledClass(activeError);
	wire        alarm       = (cls != 2'h0);

	always @(posedge clk) begin
		if (reset) begin
			activeError  <= 10'h0;
			heatCnt_q    <= 16'h0;
			heatRun_q    <= 1'b0;
			restartCnt_q <= 16'h0;
		end else begin
			// clear on falling reset; new error wins
			if (newErr)
				activeError <= newCode;
			else if (rstFall)
				activeError <= 10'h0;
			if (rstFall && alarm)
				restartCnt_q <= restartMs_q;
			else if (tick && restartBusy)
				restartCnt_q <= restartCnt_q - 16'h1;
			// timed from start to 95 percent
			if (startRise && huEn) begin
				heatRun_q <= 1'b1;
				heatCnt_q <= 16'h0;
			end else if (!startOn || reached || heatTimeout) begin
				heatRun_q <= 1'b0;
			end else if (tick && heatRun_q) begin
				heatCnt_q <= heatCnt_q + 16'h1;
			end
		end
	end

	// ==================================================
	// Measurement pause limit
	reg  [3:0]  pauseCnt_q;
	reg         mainsPrev_q;
	reg  [1:0]  mainsSync_q;
	wire        period = mainsSync_q[1] & ~mainsPrev_q;
	wire        control = startOn && !cprOn;
	wire        wantPause = control && over && powerReduce;

	always @(posedge clk) begin
		if (reset) begin
			mainsSync_q   <= 2'h0;
			mainsPrev_q   <= 1'b0;
			pauseCnt_q    <= 4'h0;
			powerReduce   <= 1'b0;
			measureEnable <= 1'b0;
		end else begin
			mainsSync_q <= {mainsSync_q[0], mainsPeriod};
			mainsPrev_q <= mainsSync_q[1];
			powerReduce <= control && over;
			if (!wantPause)
				pauseCnt_q <= 4'h0;
			else if (period && pauseCnt_q < pauseMax_q)
				pauseCnt_q <= pauseCnt_q + 4'h1;
			measureEnable <= !restartBusy && !(wantPause && pauseCnt_q < pauseMax_q);
		end
	end

	// ==================================================
	// Status output
	reg         latchArm_q;
	always @(posedge clk) begin
		if (reset) begin
			tempStatus <= 1'b0;
			latchArm_q <= 1'b0;
		end else begin
			case (mode)
				`TSA_MODE_OFF: tempStatus <= 1'b0;
				`TSA_MODE_REACHED: tempStatus <= startOn && !alarm &&
					(reached || tempStatus);
				`TSA_MODE_FOLLOW: tempStatus <= startOn && !alarm && inBand;
				`TSA_MODE_LATCHED: begin
					if (startRise || alarm) begin
						tempStatus <= 1'b0;
						latchArm_q <= startRise && !alarm;
					end else if (latchArm_q && startOn && inBand) begin
						tempStatus <= 1'b1;
					end else if (tempStatus && !inBand) begin
						tempStatus <= 1'b0;
						latchArm_q <= 1'b0;
					end
				end
				default: tempStatus <= 1'b0;
			endcase
			if (cprOn)
				tempStatus <= 1'b0;
		end
	end

	// ==================================================
	// Alarm indicator
	reg  [8:0]  blinkCnt_q;
	reg         blink4_q;
	reg         blink1_q;
	reg  [1:0]  phase_q;
	always @(posedge clk) begin
		if (reset) begin
			blinkCnt_q <= 9'h0;
			phase_q    <= 2'h0;
			blink4_q   <= 1'b0;
			blink1_q   <= 1'b0;
			alarmLed   <= 1'b0;
			alarmOut   <= 1'b0;
		end else begin
			if (tick) begin
				if (blinkCnt_q == BLINK_LAST_I[8:0]) begin
					blinkCnt_q <= 9'h0;
					blink4_q   <= ~blink4_q;
					phase_q    <= phase_q + 2'h1;
					if (phase_q == 2'h3)
						blink1_q <= ~blink1_q;
				end else begin
					blinkCnt_q <= blinkCnt_q + 9'h1;
				end
			end
			case (cls)
				2'h1: alarmLed <= startOn ? 1'b1 : blink4_q;
				2'h2: alarmLed <= startOn ? 1'b1 : blink1_q;
				2'h3: alarmLed <= 1'b1;
				default: alarmLed <= 1'b0;
			endcase
			alarmOut <= (cls == 2'h3) || (alarm && startOn);
		end
	end

	// ==================================================
	// Message log
	// Ring of 400 entries; code and stamp kept in separate arrays
	reg  [9:0]  logCode [0:`TSA_LOG_DEPTH-1];
	reg  [31:0] logTime [0:`TSA_LOG_DEPTH-1];
	reg  [8:0]  wrPtr_q;
	reg  [8:0]  logCnt_q;
	always @(posedge clk) begin
		if (reset) begin
			wrPtr_q  <= 9'h0;
			logCnt_q <= 9'h0;
		end else if (newErr) begin
			logCode[wrPtr_q] <= newCode;
			logTime[wrPtr_q] <= clkSet ? clock_q : `TSA_TIME_INVALID;
			wrPtr_q <= (wrPtr_q == LOG_LAST_I[8:0]) ? 9'h0 : wrPtr_q + 9'h1;
			if (logCnt_q != LOG_DEPTH_I[8:0])
				logCnt_q <= logCnt_q + 9'h1;
		end
	end

	// ==================================================
	// Read path
	wire [8:0]  rdIdx = (logIdx_q < LOG_DEPTH_I[8:0]) ? logIdx_q : 9'h0;
	always @* begin
		case (paddr)
			`TSA_OFF_CTRL:    prdata = {28'h0, ctrl_q};
			`TSA_OFF_BAND:    prdata = {16'h0, bandHi_q, bandLo_q};
			`TSA_OFF_HEATLIM: prdata = {16'h0, heatLim_q};
			`TSA_OFF_RESTART: prdata = {16'h0, restartMs_q};
			`TSA_OFF_PAUSE:   prdata = {28'h0, pauseMax_q};
			`TSA_OFF_STATUS:  prdata = {26'h0, restartBusy, heatRun_q, alarmLed,
				alarmOut, tempStatus, measureEnable};
			`TSA_OFF_ERRCODE: prdata = {22'h0, activeError};
			`TSA_OFF_LOGIDX:  prdata = {23'h0, logIdx_q};
			`TSA_OFF_LOGDATA: prdata = {logTime[rdIdx][21:0], logCode[rdIdx]};
			`TSA_OFF_LOGCNT:  prdata = {7'h0, wrPtr_q, 7'h0, logCnt_q};
			`TSA_OFF_CLOCK:   prdata = clock_q;
			default:          prdata = 32'h0;
		endcase
	end

endmodule

//--- inc/tsa_defs.vh
// Purpose: Constants for the temperature status and alarm logic
// Assumes: 125 MHz clock, APB register access, 32-bit data
// Notes:   Offsets are byte addresses
`ifndef TSA_DEFS_VH
`define TSA_DEFS_VH

// ==================================================
// Register offsets
`define TSA_OFF_CTRL      12'h000
`define TSA_OFF_BAND      12'h004
`define TSA_OFF_HEATLIM   12'h008
`define TSA_OFF_RESTART   12'h00c
`define TSA_OFF_PAUSE     12'h010
`define TSA_OFF_STATUS    12'h014
`define TSA_OFF_ERRCODE   12'h018
`define TSA_OFF_LOGIDX    12'h01c
`define TSA_OFF_LOGDATA   12'h020
`define TSA_OFF_LOGCNT    12'h024
`define TSA_OFF_CLOCK     12'h028

// ==================================================
// Control fields
`define TSA_CTRL_MODE_LO  0
`define TSA_CTRL_MODE_HI  1
`define TSA_CTRL_HUEN     2
`define TSA_CTRL_CLKSET   3

// ==================================================
// Output modes
`define TSA_MODE_OFF      2'h0
`define TSA_MODE_REACHED  2'h1
`define TSA_MODE_FOLLOW   2'h2
`define TSA_MODE_LATCHED  2'h3

// ==================================================
// Reset values
`define TSA_RST_CTRL      4'h1
`define TSA_RST_BANDLO    8'h0a
`define TSA_RST_BANDHI    8'h0a
`define TSA_RST_HEATLIM   16'h0064
`define TSA_RST_PAUSE     4'ha

// ==================================================
// Timing
`define TSA_CLK_HZ        125000000
`define TSA_TICK_MS       1
`define TSA_TICK_CYC      (`TSA_CLK_HZ / 1000 * `TSA_TICK_MS)
`define TSA_RESTART_MS    16'h00c8
`define TSA_BLINK4_HZ     4
`define TSA_BLINK1_HZ     1
`define TSA_BLINK4_MS     (1000 / (2 * `TSA_BLINK4_HZ))
`define TSA_BLINK1_MS     (1000 / (2 * `TSA_BLINK1_HZ))

// ==================================================
// Error codes and log
`define TSA_ERR_HEATUP    10'd304
`define TSA_LOG_DEPTH     400
`define TSA_RATIO_NUM     19
`define TSA_RATIO_DEN     20
`define TSA_TIME_INVALID  32'hffffffff

`endif

//--- verification/tsa_status_alarm_sva.sv
// Purpose: Assertions on status, power and alarm outputs
// Assumes: Sync reset; mode and band mirrored from APB writes
// Notes:   Repetition slack covers the pin synchronisers
`timescale 1ns/100ps
`include "tsa_defs.vh"
module tsa_status_alarm_sva (
	input wire        clk,
	input wire        reset,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        startPin,
	input wire        resetPin,
	input wire        constantPowerRequestPin,
	input wire [11:0] actualTemp,
	input wire [11:0] setpointTemp,
	input wire        tempStatus,
	input wire        alarmLed,
	input wire        powerReduce,
	input wire [9:0]  activeError
);
	reg  [1:0]  modeQ;
	reg  [7:0]  bandLoQ;
	reg  [7:0]  bandHiQ;
	reg  [3:0]  sinceStartQ;
	wire        wrAcc   = psel && penable && pwrite;
	wire [12:0] loSum   = {1'b0, actualTemp} + {5'h0, bandLoQ};
	wire [12:0] hiLim   = {1'b0, setpointTemp} + {5'h0, bandHiQ};
	wire        outBand = (loSum < {1'b0, setpointTemp}) || ({1'b0, actualTemp} > hiLim);
	// ======
	// Mirrors of writable fields
	always @(posedge clk) begin
		if (reset) begin
			modeQ   <= `TSA_MODE_REACHED;
			bandLoQ <= `TSA_RST_BANDLO;
			bandHiQ <= `TSA_RST_BANDHI;
		end else if (wrAcc && paddr == `TSA_OFF_CTRL) begin
			modeQ <= pwdata[1:0];
		end else if (wrAcc && paddr == `TSA_OFF_BAND) begin
			bandLoQ <= pwdata[7:0];
			bandHiQ <= pwdata[15:8];
		end
	end
	// Saturating, so a long weld never wraps back into the re-arm window
	always @(posedge clk) begin
		if (reset || $rose(startPin)) begin
			sinceStartQ <= 4'h0;
		end else if (sinceStartQ != 4'hf) begin
			sinceStartQ <= sinceStartQ + 4'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ======
	// Assertions
	sequence sPowerReq;
		constantPowerRequestPin [*5];
	endsequence
	sequence sStartLow;
		(modeQ == `TSA_MODE_REACHED && !startPin) [*5];
	endsequence
	a_power_req_off: assert property
		(sPowerReq |-> !tempStatus) else $error("status high under power request");
	a_off_mode_low: assert property
		((modeQ == `TSA_MODE_OFF) [*2] |-> !tempStatus) else $error("status high in off mode");
	a_reached_start_low: assert property
		(sStartLow |-> !tempStatus) else $error("status high with start low");
	a_follow_out_band: assert property
		((modeQ == `TSA_MODE_FOLLOW && outBand) [*3] |-> !tempStatus)
		else $error("status high outside band");
	a_latched_no_reentry: assert property
		(modeQ == `TSA_MODE_LATCHED && sinceStartQ > 4'h4 && $fell(tempStatus) |=>
		(!tempStatus || sinceStartQ < 4'h4) [*8]) else $error("latched status came back");
	a_reduce_needs_over: assert property
		((actualTemp <= setpointTemp) [*2] |-> !powerReduce) else $error("power cut not over");
	a_steady_led_on: assert property
		((activeError == 10'h065) [*2] |-> alarmLed) else $error("alarm light not steady");
	a_clear_on_fall: assert property
		((resetPin && activeError != 10'h000) [*6] |=> activeError != 10'h000)
		else $error("error cleared while acknowledge high");
endmodule
bind tsa_status_alarm tsa_status_alarm_sva i_tsa_status_alarm_sva (
	.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .startPin, .resetPin,
	.constantPowerRequestPin, .actualTemp, .setpointTemp, .tempStatus, .alarmLed,
	.powerReduce, .activeError
);

//--- verification/tsa_machine_ctrl.sv
// Purpose: Machine controller model for start, acknowledge and power request
// Assumes: Levels change right after a rising clock edge
// Notes:   Levels hold until the next call
`timescale 1ns/100ps
module tsa_machine_ctrl (
	input  wire clk,
	output reg  startPin,
	output reg  resetPin,
	output reg  constantPowerRequestPin
);
	initial begin
		startPin                = 1'b0;
		resetPin                = 1'b0;
		constantPowerRequestPin = 1'b0;
	end
	// ======
	// Pin levels, p is {power request, acknowledge, start}
	task drive(input logic [2:0] p);
		@(posedge clk);
		startPin                <= p[0];
		resetPin                <= p[1];
		constantPowerRequestPin <= p[2];
	endtask
endmodule

//--- verification/temp_status_alarm_logic_bench.sv
// Purpose: Self-checking bench for the status and alarm logic
// Assumes: Zero-wait APB; pins seen three edges after a change
// Notes:   Millisecond timers are too slow here; only their defaults are read
`timescale 1ns/100ps
`include "tsa_defs.vh"
module temp_status_alarm_logic_bench;
	localparam logic [11:0] RA [0:5] = '{`TSA_OFF_CTRL, `TSA_OFF_BAND, `TSA_OFF_HEATLIM,
		`TSA_OFF_RESTART, `TSA_OFF_PAUSE, 12'hffc};
	localparam logic [31:0] RV [0:5] = '{32'h1, 32'ha0a, 32'h64, 32'hc8, 32'ha, 32'h0};
	reg         clk;
	reg         reset;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg  [11:0] paddr;
	reg  [31:0] pwdata;
	wire        pready;
	wire [31:0] prdata;
	wire        pslverr;
	wire        startPin;
	wire        resetPin;
	wire        constantPowerRequestPin;
	reg  [11:0] actualTemp;
	reg  [11:0] setpointTemp;
	reg         errEvent;
	reg  [9:0]  errCode;
	reg         mainsPeriod;
	wire        tempStatus;
	wire        alarmOut;
	wire        alarmLed;
	wire        measureEnable;
	wire        powerReduce;
	wire [9:0]  activeError;
	reg  [31:0] rd;
	int         badCount;
	int         nTests;
	tsa_status_alarm i_tsa_status_alarm (
		.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.startPin, .resetPin, .constantPowerRequestPin, .actualTemp, .setpointTemp,
		.mainsPeriod, .errEvent, .errCode, .tempStatus, .alarmOut, .alarmLed,
		.measureEnable, .powerReduce, .activeError
	);
	tsa_machine_ctrl i_tsa_machine_ctrl (
		.clk, .startPin, .resetPin, .constantPowerRequestPin
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ======
	// Tasks
	task report_and_stop;
		if (badCount == 0 && nTests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			badCount++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			badCount++;
			report_and_stop();
		end
	endtask
	// Pin set is {power request, acknowledge, start}
	task pin(input logic [2:0] p);
		i_tsa_machine_ctrl.drive(p);
		cyc(6);
	endtask
	task temp(input logic [11:0] t);
		@(posedge clk);
		actualTemp <= t;
		cyc(4);
	endtask
	// One mains period marker, long enough for the pin synchroniser
	task mains;
		@(posedge clk);
		mainsPeriod <= 1'b1;
		repeat (4) @(posedge clk);
		mainsPeriod <= 1'b0;
		cyc(4);
	endtask
	task err(input logic [9:0] c);
		@(posedge clk);
		errEvent <= 1'b1;
		errCode  <= c;
		@(posedge clk);
		errEvent <= 1'b0;
		cyc(3);
	endtask
	// ======
	// Main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		actualTemp = 12'h000;
		setpointTemp = 12'h0c8;
		errEvent = 1'b0;
		errCode = 10'h000;
		mainsPeriod = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		cyc(2);
		chk("measure enable", 32'h1, measureEnable);
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, RA[k], 32'h0);
			chk("reset value", RV[k], rd);
		end
		apb(1'b1, `TSA_OFF_PAUSE, 32'hc);
		apb(1'b0, `TSA_OFF_PAUSE, 32'h0);
		chk("pause limit", 32'ha, rd);
		apb(1'b1, `TSA_OFF_PAUSE, 32'h2);
		apb(1'b1, `TSA_OFF_RESTART, 32'h0);
		pin(3'h1);
		temp(12'h0be);
		chk("status", 32'h0, tempStatus);
		temp(12'h0bf);
		chk("status", 32'h1, tempStatus);
		chk("reduce", 32'h0, powerReduce);
		temp(12'h0d2);
		chk("reduce", 32'h1, powerReduce);
		chk("measure enable", 32'h0, measureEnable);
		mains();
		chk("measure enable", 32'h0, measureEnable);
		mains();
		chk("measure enable", 32'h1, measureEnable);
		pin(3'h0);
		chk("status", 32'h0, tempStatus);
		apb(1'b1, `TSA_OFF_CTRL, 32'h2);
		pin(3'h1);
		temp(12'h0c8);
		chk("status", 32'h1, tempStatus);
		temp(12'h0d3);
		chk("status", 32'h0, tempStatus);
		temp(12'h0c8);
		chk("status", 32'h1, tempStatus);
		pin(3'h5);
		chk("status", 32'h0, tempStatus);
		apb(1'b1, `TSA_OFF_CTRL, 32'h3);
		pin(3'h0);
		pin(3'h1);
		chk("status", 32'h1, tempStatus);
		pin(3'h0);
		chk("status", 32'h1, tempStatus);
		pin(3'h1);
		temp(12'h096);
		chk("status", 32'h0, tempStatus);
		temp(12'h0c8);
		chk("status", 32'h0, tempStatus);
		apb(1'b1, `TSA_OFF_CTRL, 32'h0);
		cyc(3);
		chk("status", 32'h0, tempStatus);
		apb(1'b1, `TSA_OFF_CTRL, 32'h1);
		cyc(3);
		chk("status", 32'h1, tempStatus);
		err(10'h065);
		chk("status", 32'h0, tempStatus);
		chk("alarm light", 32'h1, alarmLed);
		chk("alarm out", 32'h1, alarmOut);
		pin(3'h3);
		chk("error", 32'h65, activeError);
		pin(3'h0);
		chk("error", 32'h0, activeError);
		err(10'h12e);
		chk("alarm out", 32'h0, alarmOut);
		pin(3'h1);
		chk("alarm out", 32'h1, alarmOut);
		chk("alarm light", 32'h1, alarmLed);
		apb(1'b0, `TSA_OFF_LOGCNT, 32'h0);
		chk("log count", 32'h2, rd & 32'h1ff);
		apb(1'b0, `TSA_OFF_LOGDATA, 32'h0);
		chk("log entry", 32'hfffffc65, rd);
		report_and_stop();
	end
endmodule
